// ---- mc_params.svh ----
// Constants for the machine-check error classifier.
`ifndef MC_PARAMS_SVH
`define MC_PARAMS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define MC_NUM_BANKS 4
`define MC_BANK_IDX_W 2
`define MC_NUM_CPUS 4
`define MC_CPU_IDX_W 2
`define MC_CODE_W 16

// ****************************************************************
// Reset values and fixed patterns
// ****************************************************************
`define MC_FLAGS_RESET 7'h00
`define MC_CODE_RESET 16'h0000
`define MC_ALL_CPUS 4'hF
`define MC_ONE_CPU 4'h1
`define MC_NO_CPUS 4'h0

`endif

// ---- mc_pkg.sv ----
// Types shared by the machine-check error classifier modules.
`include "mc_params.svh"

package mc_pkg;

  // ****************************************************************
  // Bank status flags
  // ****************************************************************
  typedef struct packed {
    logic info_present_flag;
    logic overflow_flag;
    logic uncorrected_flag;
    logic enable_flag;
    logic context_corrupt_flag;
    logic signaled_flag;
    logic action_required_flag;
  } bank_flags_t;

  // ****************************************************************
  // Error classes
  // ****************************************************************
  typedef enum logic [2:0] {
    CLASS_NONE,
    CLASS_CORRECTED,
    CLASS_FATAL,
    CLASS_PASSIVE,
    CLASS_OPTIONAL,
    CLASS_REQUIRED
  } error_class_t;

endpackage

// ---- bank_class_if.sv ----
// Interface carrying one bank's flags to its classifier and the class back.
interface bank_class_if;
  import mc_pkg::*;

  bank_flags_t flags;
  logic recovery_capable;
  error_class_t error_class;
  logic recoverable_uncorrected;

  modport store (
    output flags,
    output recovery_capable,
    input error_class,
    input recoverable_uncorrected
  );

  modport classify (
    input flags,
    input recovery_capable,
    output error_class,
    output recoverable_uncorrected
  );
endinterface

// ---- bank_classifier.sv ----
// Combinational class decoder for one error-reporting bank.
module bank_classifier (
  bank_class_if.classify bank
);
  import mc_pkg::*;

  logic valid_uc;
  logic passive;

  assign valid_uc = bank.flags.info_present_flag &
                    bank.flags.uncorrected_flag;
  assign passive = ~bank.flags.context_corrupt_flag &
                   ~bank.flags.signaled_flag &
                   ~bank.flags.action_required_flag;

  // Enabled, uncorrupted, uncorrected errors are recoverable.
  assign bank.recoverable_uncorrected = valid_uc & bank.recovery_capable &
      bank.flags.enable_flag & ~bank.flags.context_corrupt_flag;

  always_comb begin
    if (!bank.flags.info_present_flag) begin
      bank.error_class = CLASS_NONE;
    end else if (!bank.flags.uncorrected_flag) begin
      bank.error_class = CLASS_CORRECTED;
    end else if (!bank.recovery_capable) begin
      bank.error_class = CLASS_FATAL;
    end else if (bank.flags.context_corrupt_flag) begin
      bank.error_class = CLASS_FATAL;
    end else if (passive) begin
      bank.error_class = CLASS_PASSIVE;
    end else if (!bank.flags.enable_flag) begin
      // A disabled error never caused an exception; software only logs it.
      bank.error_class = CLASS_PASSIVE;
    end else if (!bank.flags.signaled_flag) begin
      // Action required without signaled is an illegal combination.
      bank.error_class = CLASS_FATAL;
    end else if (bank.flags.action_required_flag) begin
      bank.error_class = CLASS_REQUIRED;
    end else begin
      bank.error_class = CLASS_OPTIONAL;
    end
  end
endmodule // bank_classifier

// ---- machine_check_error_classifier.sv ----
// Machine-check bank logging, error classification and exception signalling.
//
// How it works
// - Without recovery support every uncorrected error is classed fatal.
// - With recovery support uncorrected errors may be classed recoverable.
// - Without local reporting an exception goes to every logical processor.
// - Local reporting, capable and enabled, targets only the own processor.
// - Each bank has a present flag; clear means no valid information.
// - Each bank has an uncorrected flag: zero corrected, one uncorrected.
// - Error-IP flag set only when saved pointer relates to the error.
// - Raising an exception sets in-progress; other vector 18 events do not.
// - Enabled uncorrected error with corrupt context: recovery impossible.
// - Restart-IP set only when restart at the saved pointer is reliable.
// - Uncorrected errors with enable clear never raise an exception when logged; consuming their data later can.
// - Present, uncorrected, enabled, uncorrupted: recoverable-uncorrected.
// - Uncorrected, no corrupt, signaled or action flag: corrected interrupt.
// - Consuming passive corrupt data raises an action-required exception.
// - Signaled recoverable errors come by exception; action flag subtypes.
// - Signaled without action-required is optional; code held in bank.
// - Software clears in-progress; exception while set causes shutdown.
`include "mc_params.svh"

module machine_check_error_classifier (
  input wire logic clock,
  input wire logic srst,
  input wire logic recovery_capable,
  input wire logic local_report_capable,
  input wire logic local_report_enable,
  input wire logic [`MC_CPU_IDX_W-1:0] own_cpu_index,
  input wire logic err_valid,
  input wire logic [`MC_BANK_IDX_W-1:0] err_bank,
  input wire mc_pkg::bank_flags_t err_flags,
  input wire logic [`MC_CODE_W-1:0] err_code,
  input wire logic ctx_restart_ok,
  input wire logic ctx_ip_related,
  input wire logic consume_valid,
  input wire logic [`MC_BANK_IDX_W-1:0] consume_bank,
  input wire logic [`MC_NUM_BANKS-1:0] bank_clear,
  input wire logic clear_in_progress,
  output mc_pkg::bank_flags_t [`MC_NUM_BANKS-1:0] bank_state,
  output logic [`MC_NUM_BANKS-1:0][`MC_CODE_W-1:0] bank_code,
  output mc_pkg::error_class_t [`MC_NUM_BANKS-1:0] bank_class,
  output logic [`MC_NUM_BANKS-1:0] recoverable_uncorrected,
  output logic recovery_impossible,
  output logic restart_ip_ok,
  output logic error_ip_related,
  output logic exception_in_progress,
  output logic shutdown,
  output logic check_exception,
  output logic [`MC_NUM_CPUS-1:0] check_targets,
  output logic corrected_error_interrupt
);
  import mc_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  bank_flags_t [`MC_NUM_BANKS-1:0] flags_q;
  logic [`MC_NUM_BANKS-1:0][`MC_CODE_W-1:0] code_q;
  logic in_progress_q;
  logic restart_q;
  logic ip_related_q;
  logic shutdown_q;
  logic check_q;
  logic [`MC_NUM_CPUS-1:0] targets_q;
  logic corrected_error_interrupt_q;

  // ****************************************************************
  // Incoming error shaping
  // ****************************************************************
  bank_flags_t new_flags;
  logic new_passive;
  logic new_raise;
  logic new_corrected_error_interrupt;
  logic new_corrupt;

  always_comb begin
    new_flags = err_flags;
    new_flags.info_present_flag = 1'b1;
    new_flags.overflow_flag = 1'b0;
    if (new_flags.uncorrected_flag && !recovery_capable) begin
      // No recoverable classes exist: mark the context lost.
      new_flags.context_corrupt_flag = 1'b1;
      new_flags.signaled_flag = 1'b0;
      new_flags.action_required_flag = 1'b0;
    end
    if (new_flags.uncorrected_flag && new_flags.enable_flag &&
        !new_flags.context_corrupt_flag &&
        (new_flags.action_required_flag || new_flags.signaled_flag)) begin
      // Recoverable errors of the exception path are always signaled.
      new_flags.signaled_flag = 1'b1;
    end
  end

  assign new_passive = new_flags.uncorrected_flag &
                       ~new_flags.context_corrupt_flag &
                       ~new_flags.signaled_flag &
                       ~new_flags.action_required_flag;

  // Only enabled, non-passive uncorrected errors trap.
  assign new_raise = err_valid & new_flags.uncorrected_flag &
                     new_flags.enable_flag & ~new_passive;

  // Corrected and passive errors take the interrupt path.
  assign new_corrected_error_interrupt = err_valid &
                    (~new_flags.uncorrected_flag | new_passive);

  assign new_corrupt = new_flags.context_corrupt_flag;

  // ****************************************************************
  // Consumption of poisoned data
  // ****************************************************************
  bank_flags_t cons_flags;
  logic cons_hit;

  assign cons_flags = flags_q[consume_bank];
  assign cons_hit = consume_valid & (bank_class[consume_bank] ==
                                     CLASS_PASSIVE) &
                    ~cons_flags.signaled_flag;

  // ****************************************************************
  // Bank registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int b = 0; b < `MC_NUM_BANKS; b++) begin
        flags_q[b] <= `MC_FLAGS_RESET;
        code_q[b] <= `MC_CODE_RESET;
      end
    end else begin
      for (int b = 0; b < `MC_NUM_BANKS; b++) begin
        // A clear and a new error in one cycle: the error survives.
        if (bank_clear[b]) begin
          flags_q[b] <= `MC_FLAGS_RESET;
        end
        if (err_valid && err_bank == b[`MC_BANK_IDX_W-1:0]) begin
          if (!bank_clear[b] && flags_q[b].info_present_flag) begin
            // Keep an older uncorrected record over a newer corrected one.
            if (flags_q[b].uncorrected_flag &&
                !new_flags.uncorrected_flag) begin
              flags_q[b].overflow_flag <= 1'b1;
            end else begin
              flags_q[b] <= new_flags;
              flags_q[b].overflow_flag <= 1'b1;
              code_q[b] <= err_code;
            end
          end else begin
            flags_q[b] <= new_flags;
            code_q[b] <= err_code;
          end
        end else if (cons_hit && consume_bank == b[`MC_BANK_IDX_W-1:0] &&
                     !bank_clear[b]) begin
          flags_q[b].enable_flag <= 1'b1;
          flags_q[b].signaled_flag <= 1'b1;
          flags_q[b].action_required_flag <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Classification
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `MC_NUM_BANKS; g++) begin : gen_bank
      bank_class_if bank_bus ();

      assign bank_bus.flags = flags_q[g];
      assign bank_bus.recovery_capable = recovery_capable;
      assign bank_class[g] = bank_bus.error_class;
      assign recoverable_uncorrected[g] = bank_bus.recoverable_uncorrected;

      bank_classifier u_classifier (
        .bank (bank_bus.classify)
      );
    end
  endgenerate

  // An enabled uncorrected error with corrupt context anywhere.
  always_comb begin
    recovery_impossible = 1'b0;
    for (int b = 0; b < `MC_NUM_BANKS; b++) begin
      if (flags_q[b].info_present_flag && flags_q[b].uncorrected_flag &&
          flags_q[b].enable_flag && flags_q[b].context_corrupt_flag) begin
        recovery_impossible = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Exception sequencing
  // ****************************************************************
  logic raise;
  logic recursion;
  logic raise_corrupt;

  assign raise = new_raise | cons_hit;
  // A clear in the same cycle means the handler has already returned.
  assign recursion = raise & in_progress_q & ~clear_in_progress;
  assign raise_corrupt = new_raise & new_corrupt;

  // Only a generated exception sets this; a software vector 18 never does.
  always_ff @(posedge clock) begin
    if (srst) begin
      in_progress_q <= 1'b0;
    end else if (raise && !recursion && !shutdown_q) begin
      in_progress_q <= 1'b1;
    end else if (clear_in_progress) begin
      in_progress_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      shutdown_q <= 1'b0;
    end else if (recursion) begin
      shutdown_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      restart_q <= 1'b0;
      ip_related_q <= 1'b0;
    end else if (raise && !recursion && !shutdown_q) begin
      restart_q <= ctx_restart_ok & ~raise_corrupt;
      ip_related_q <= ctx_ip_related;
    end else if (clear_in_progress) begin
      restart_q <= 1'b0;
      ip_related_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Delivery
  // ****************************************************************
  logic [`MC_NUM_CPUS-1:0] local_mask;

  assign local_mask = `MC_ONE_CPU << own_cpu_index;

  always_ff @(posedge clock) begin
    if (srst) begin
      check_q <= 1'b0;
      targets_q <= `MC_NO_CPUS;
    end else begin
      check_q <= raise & ~recursion & ~shutdown_q;
      if (raise && !recursion && !shutdown_q) begin
        if (local_report_capable && local_report_enable) begin
          targets_q <= local_mask;
        end else begin
          targets_q <= `MC_ALL_CPUS;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      corrected_error_interrupt_q <= 1'b0;
    end else begin
      corrected_error_interrupt_q <= new_corrected_error_interrupt & ~shutdown_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bank_state = flags_q;
  assign bank_code = code_q;
  assign restart_ip_ok = restart_q;
  assign error_ip_related = ip_related_q;
  assign exception_in_progress = in_progress_q;
  assign shutdown = shutdown_q;
  assign check_exception = check_q;
  assign check_targets = targets_q;
  assign corrected_error_interrupt = corrected_error_interrupt_q;

endmodule // machine_check_error_classifier

// ---- machine_check_error_classifier_assertions.sv ----
// Concurrent checks on the ports of the machine-check error classifier.
`include "mc_params.svh"

module mc_classifier_checker
  import mc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic recovery_capable,
  input wire logic local_report_enable,
  input wire logic err_valid,
  input wire mc_pkg::bank_flags_t err_flags,
  input wire logic consume_valid,
  input wire logic clear_in_progress,
  input wire mc_pkg::bank_flags_t [`MC_NUM_BANKS-1:0] bank_state,
  input wire mc_pkg::error_class_t [`MC_NUM_BANKS-1:0] bank_class,
  input wire logic [`MC_NUM_BANKS-1:0] recoverable_uncorrected,
  input wire logic recovery_impossible,
  input wire logic restart_ip_ok,
  input wire logic exception_in_progress,
  input wire logic shutdown,
  input wire logic check_exception,
  input wire logic [`MC_NUM_CPUS-1:0] check_targets,
  input wire logic corrected_error_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // ****************************************************************
  // Exception signalling
  // ****************************************************************
  property p_exc_ip;
    check_exception |-> exception_in_progress;
  endproperty
  a_exc_ip: assert property (p_exc_ip) else $error("no in-progress");
  property p_recursion;
    err_valid && err_flags.uncorrected_flag && err_flags.enable_flag &&
      err_flags.context_corrupt_flag && exception_in_progress &&
      !clear_in_progress |=> shutdown && !check_exception;
  endproperty
  a_recursion: assert property (p_recursion) else $error("no halt");
  property p_shutdown;
    shutdown |=> shutdown && !check_exception;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("left halt");
  property p_no_enable;
    err_valid && err_flags.uncorrected_flag && !err_flags.enable_flag &&
      !consume_valid |=> !check_exception;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("raised");
  property p_corrected;
    err_valid && !err_flags.uncorrected_flag && !consume_valid && !shutdown
      |=> corrected_error_interrupt && !check_exception;
  endproperty
  a_corrected: assert property (p_corrected) else $error("bad path");
  property p_restart;
    err_valid && err_flags.context_corrupt_flag && !consume_valid
      |=> !check_exception || !restart_ip_ok;
  endproperty
  a_restart: assert property (p_restart) else $error("restart set");
  property p_broadcast;
    err_valid && !local_report_enable
      |=> !check_exception || check_targets == `MC_ALL_CPUS;
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("not all");

  // ****************************************************************
  // Classification of bank one
  // ****************************************************************
  property p_fatal;
    !recovery_capable && bank_state[1].info_present_flag &&
      bank_state[1].uncorrected_flag |-> bank_class[1] == CLASS_FATAL;
  endproperty
  a_fatal: assert property (p_fatal) else $error("not fatal");
  property p_ucr;
    recovery_capable && bank_state[1].info_present_flag &&
      bank_state[1].uncorrected_flag && bank_state[1].enable_flag &&
      !bank_state[1].context_corrupt_flag |-> recoverable_uncorrected[1];
  endproperty
  a_ucr: assert property (p_ucr) else $error("not recoverable");
  property p_impossible;
    bank_state[1].info_present_flag && bank_state[1].uncorrected_flag &&
      bank_state[1].enable_flag && bank_state[1].context_corrupt_flag
      |-> recovery_impossible;
  endproperty
  a_impossible: assert property (p_impossible) else $error("no flag");
endmodule // mc_classifier_checker

// ---- tb_machine_check_error_classifier.sv ----
// Self-checking testbench for the machine-check error classifier.
`include "mc_params.svh"

module tb_machine_check_error_classifier;
  timeunit 1ns;
  timeprecision 1ps;
  import mc_pkg::*;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic recovery_capable = 1'b1;
  logic local_report_capable = 1'b0;
  logic local_report_enable = 1'b0;
  logic [`MC_CPU_IDX_W-1:0] own_cpu_index = 2'h2;
  logic err_valid = 1'b0;
  logic [`MC_BANK_IDX_W-1:0] err_bank = 2'h0;
  bank_flags_t err_flags = 7'h00;
  logic [`MC_CODE_W-1:0] err_code = 16'h1234;
  logic ctx_restart_ok = 1'b1;
  logic ctx_ip_related = 1'b1;
  logic consume_valid = 1'b0;
  logic [`MC_BANK_IDX_W-1:0] consume_bank = 2'h3;
  logic [`MC_NUM_BANKS-1:0] bank_clear = 4'h0;
  logic clear_in_progress = 1'b0;
  bank_flags_t [`MC_NUM_BANKS-1:0] bank_state;
  logic [`MC_NUM_BANKS-1:0][`MC_CODE_W-1:0] bank_code;
  error_class_t [`MC_NUM_BANKS-1:0] bank_class;
  logic [`MC_NUM_BANKS-1:0] recoverable_uncorrected;
  logic recovery_impossible, restart_ip_ok, error_ip_related;
  logic exception_in_progress, shutdown, check_exception;
  logic corrected_error_interrupt;
  logic [`MC_NUM_CPUS-1:0] check_targets;
  int num_errors = 0;
  int check_count = 0;

  machine_check_error_classifier i_dut (
    .clock, .srst, .recovery_capable, .local_report_capable,
    .local_report_enable, .own_cpu_index, .err_valid, .err_bank,
    .err_flags, .err_code, .ctx_restart_ok, .ctx_ip_related,
    .consume_valid, .consume_bank, .bank_clear, .clear_in_progress,
    .bank_state, .bank_code, .bank_class, .recoverable_uncorrected,
    .recovery_impossible, .restart_ip_ok, .error_ip_related,
    .exception_in_progress, .shutdown, .check_exception, .check_targets,
    .corrected_error_interrupt
  );

  always #20 clock = ~clock;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Inputs move 1 ns after the edge so the design samples them settled.
  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic log_err(input logic [1:0] b, input logic [6:0] f);
    err_valid = 1'b1;
    err_bank = b;
    err_flags = f;
    tick;
    err_valid = 1'b0;
  endtask

  // Clearing in-progress after each raise keeps later raises legal.
  task automatic tidy;
    bank_clear = 4'hF;
    clear_in_progress = 1'b1;
    tick;
    bank_clear = 4'h0;
    clear_in_progress = 1'b0;
  endtask

  // Software asks for a system reset: one edge of srst, then released.
  task automatic reset_dut;
    srst = 1'b1;
    tick;
    srst = 1'b0;
    check(exception_in_progress, 0);
    check(shutdown, 0);
    check(bank_class[1], CLASS_NONE);
  endtask

  task automatic complete_run;
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_walk;
    log_err(2'h0, 7'h1A);
    check(check_exception, 1);
    check(exception_in_progress, 1);
    check(bank_class[0], CLASS_OPTIONAL);
    check(bank_code[0], 16'h1234);
    check(restart_ip_ok, 1);
    check(error_ip_related, 1);
    check(check_targets, `MC_ALL_CPUS);
    check(recoverable_uncorrected[0], 1);
    ctx_restart_ok = 1'b0;
    ctx_ip_related = 1'b0;
    tick;
    check(check_exception, 0);
    tidy;
    check(exception_in_progress, 0);
    check(bank_state[0].info_present_flag, 0);
  endtask

  task automatic s_classes;
    logic [7:0] stim [6] = '{8'h80, 8'h98, 8'h9C, 8'h9B, 8'h18, 8'h10};
    error_class_t cls [6] = '{CLASS_CORRECTED, CLASS_PASSIVE, CLASS_FATAL,
      CLASS_REQUIRED, CLASS_FATAL, CLASS_FATAL};
    logic [2:0] sig [6] = '{3'h2, 3'h2, 3'h5, 3'h4, 3'h5, 3'h0};
    for (int i = 0; i < 6; i++) begin
      recovery_capable = stim[i][7];
      log_err(2'h1, stim[i][6:0]);
      check(bank_class[1], cls[i]);
      check({check_exception, corrected_error_interrupt,
        recovery_impossible}, sig[i]);
      if (!stim[i][7]) begin
        reset_dut;
      end
      tidy;
    end
    recovery_capable = 1'b1;
  endtask

  task automatic s_local;
    local_report_capable = 1'b1;
    local_report_enable = 1'b1;
    log_err(2'h2, 7'h1B);
    check(check_targets, 4'h4);
    tidy;
    local_report_enable = 1'b0;
    log_err(2'h2, 7'h1B);
    check(check_targets, `MC_ALL_CPUS);
    tidy;
    local_report_capable = 1'b0;
  endtask

  // Overflowed optional errors may resume; overflowed required ones keep their class.
  task automatic s_software;
    ctx_restart_ok = 1'b1;
    log_err(2'h1, 7'h1A);
    clear_in_progress = 1'b1;
    tick;
    clear_in_progress = 1'b0;
    log_err(2'h1, 7'h1A);
    check(bank_state[1].overflow_flag, 1);
    check(bank_class[1], CLASS_OPTIONAL);
    check(restart_ip_ok, 1);
    check(error_ip_related, 0);
    err_code = 16'h5A5A;
    tick;
    log_err(2'h1, 7'h00);
    check(bank_code[1], 16'h1234);
    check(corrected_error_interrupt, 1);
    err_code = 16'h1234;
    tidy;
    log_err(2'h1, 7'h1B);
    clear_in_progress = 1'b1;
    tick;
    clear_in_progress = 1'b0;
    log_err(2'h1, 7'h1B);
    check(bank_state[1].overflow_flag, 1);
    check(bank_class[1], CLASS_REQUIRED);
    reset_dut;
    log_err(2'h0, 7'h1B);
    bank_clear = 4'h1;
    tick;
    bank_clear = 4'h0;
    check(exception_in_progress, 1);
    check(recoverable_uncorrected, 4'h0);
    reset_dut;
  endtask

  task automatic s_consume;
    log_err(2'h3, 7'h18);
    check(check_exception, 0);
    consume_valid = 1'b1;
    tick;
    consume_valid = 1'b0;
    check(check_exception, 1);
    check(bank_class[3], CLASS_REQUIRED);
    log_err(2'h0, 7'h1C);
    check(shutdown, 1);
    check(check_exception, 0);
    check(bank_state[0].info_present_flag, 1);
    tick;
    check(shutdown, 1);
  endtask

  initial begin
    repeat (10) tick;
    srst = 1'b0;
    s_walk;
    s_classes;
    s_local;
    s_software;
    s_consume;
    complete_run;
  end

  // The whole sequence needs under 100 cycles; this allows fifty times it.
  initial begin
    #200us;
    num_errors++;
    complete_run;
  end
endmodule // tb_machine_check_error_classifier

bind machine_check_error_classifier mc_classifier_checker i_chk (
  .clock, .srst, .recovery_capable, .local_report_enable, .err_valid,
  .err_flags, .consume_valid, .clear_in_progress, .bank_state,
  .bank_class, .recoverable_uncorrected, .recovery_impossible,
  .restart_ip_ok, .exception_in_progress, .shutdown, .check_exception,
  .check_targets, .corrected_error_interrupt
);
